// ==== hdl/vac_clamp_sync_measure.sv ====
// Clamp timing, copy-protection masking, sync measurement, gain and offset control.
// Assumes syncs already sliced and synchronous to CLK; pixel/crystal ticks are enables.
//
// Contract
// - AC coupling default; config bit selects DC
// - Clamp once per line after start count
// - Coast suppresses clamp unless coast bit set
// - Clamp lasts exactly programmed width pixels
// - Start count may exceed active line
// - Slicer threshold, hysteresis, filter from registers
// - Three selectable sync source types
// - Mask ANDed into luma composite sync
// - Mask on line sync output unless bypassed
// - Measure selected channel, results at 0x40
// - Line period, width: 16-period crystal totals
// - Frame period in lines or 512-clock units
// - Frame pulse width, same unit select
// - Gain code drives amplifier, 85 unity
// - Gain transfers on clamp, else timeout
// - Servo mode: servo averages drive offsets, registers unused
// - Servo off: registers drive 10-bit DAC
// - Half-range bit halves DAC step
// - Servo averages black pixels over lines
`timescale 1ns/100ps
module vac_clamp_sync_measure
    import vac_pkg::*;
#(
    parameter int GAIN_TIMEOUT = vac_pkg::GAIN_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RST_B,
    // Classic Wishbone slave
    input  wire logic                 CYC_I,
    input  wire logic                 STB_I,
    input  wire logic                 WE_I,
    input  wire logic [7:0]           ADR_I,
    input  wire logic [3:0]           SEL_I,
    input  wire logic [31:0]          DAT_I,
    output logic [31:0]               DAT_O,
    output logic                      ACK_O,
    // Timing enables
    input  wire logic                 PIX_TICK,
    input  wire logic                 XTAL_TICK,
    // Sync inputs from slicers, high = sync active
    input  wire logic                 HSYNC_IN,
    input  wire logic                 VSYNC_IN,
    input  wire logic                 LUMA_SYNC_IN,
    input  wire logic                 COPY_PROT_MASK,
    input  wire logic                 PLL_COASTING,
    input  wire logic                 EXT_CLAMP_IN,
    // Black level from converter, one sample per black pixel tick
    input  wire logic [9:0]           BLACK_RED,
    input  wire logic [9:0]           BLACK_GREEN,
    input  wire logic [9:0]           BLACK_BLUE,
    // Analog controls
    output logic                      DC_COUPLED,
    output logic                      CLAMP_ON,
    output logic                      PLL_SYNC,
    output logic                      LINE_SYNC_OUTPUT,
    output logic [7:0]                PHASE_GAIN,
    output vac_pkg::vac_slicer_t      SLICER,
    output logic [23:0]               GAIN_AMP_CODES,
    output vac_pkg::vac_offset_t      OFFSET_CTRL
);
    import vac_pkg::*;

    // Register storage
    logic [7:0]  off_hi_r [3];
    logic [7:0]  off_lo_r [3];
    logic [7:0]  gain_reg_r [3];
    logic [7:0]  gain_amp_r [3];
    logic [7:0]  start_a_r, start_b_r, width_r, phase_r;
    logic [7:0]  cfg_r, servo_r, slice_a_r, slice_b_r, pllc_r, meas_cfg_r, sout_r;
    logic [31:0] dat_nxt;
    logic        wr_en, rd_hit;

    assign wr_en = CYC_I && STB_I && WE_I && !ACK_O && SEL_I[0];

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ACK_O <= 1'b0;
        end else begin
            ACK_O <= CYC_I && STB_I && !ACK_O;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            for (int i = 0; i < 3; i++) begin
                off_hi_r[i]   <= OFFSET_HI_RESET;
                off_lo_r[i]   <= ZERO8;
                gain_reg_r[i] <= GAIN_RESET;
            end
            start_a_r <= ZERO8;
            start_b_r <= ZERO8;
            width_r   <= ZERO8;
            phase_r   <= PHASE_GAIN_RESET;
            cfg_r     <= ZERO8;
            servo_r   <= ZERO8;
            slice_a_r <= ZERO8;
            slice_b_r <= ZERO8;
            pllc_r    <= ZERO8;
            meas_cfg_r <= ZERO8;
            sout_r    <= ZERO8;
        end else if (wr_en) begin
            case (ADR_I)
                RED_OFFSET_HIGH:     off_hi_r[0] <= DAT_I[7:0];
                RED_OFFSET_LOW:      off_lo_r[0] <= DAT_I[7:0];
                GREEN_OFFSET_HIGH:   off_hi_r[1] <= DAT_I[7:0];
                GREEN_OFFSET_LOW:    off_lo_r[1] <= DAT_I[7:0];
                BLUE_OFFSET_HIGH:    off_hi_r[2] <= DAT_I[7:0];
                BLUE_OFFSET_LOW:     off_lo_r[2] <= DAT_I[7:0];
                GAIN_RED:            gain_reg_r[0] <= DAT_I[7:0];
                GAIN_GREEN:          gain_reg_r[1] <= DAT_I[7:0];
                GAIN_BLUE:           gain_reg_r[2] <= DAT_I[7:0];
                CLAMP_START_PIXEL_A: start_a_r <= DAT_I[7:0];
                CLAMP_START_PIXEL_B: start_b_r <= DAT_I[7:0];
                CLAMP_WIDTH_PIXELS:  width_r   <= DAT_I[7:0];
                PLL_LOOP_PHASE_GAIN: phase_r   <= DAT_I[7:0];
                INPUT_CONFIG:        cfg_r     <= DAT_I[7:0];
                BLACK_SERVO_CONFIG:  servo_r   <= DAT_I[7:0];
                SLICER_CONFIG_A:     slice_a_r <= DAT_I[7:0];
                SLICER_CONFIG_B:     slice_b_r <= DAT_I[7:0];
                PLL_CONTROL:         pllc_r    <= DAT_I[7:0];
                MEAS_CONFIG:         meas_cfg_r <= DAT_I[7:0];
                SYNC_OUT_CONFIG:     sout_r    <= DAT_I[7:0];
                default: ;
            endcase
        end
    end

    // Sync source select
    vac_sync_src_t src;
    logic          line_sync, frame_sync, masked_luma;
    assign src = vac_sync_src_t'(cfg_r[CFG_SYNC_SRC_LSB +: 2]);
    assign masked_luma = LUMA_SYNC_IN && !COPY_PROT_MASK;
    always_comb begin
        case (src)
            VAC_SRC_COMP_LUMA: line_sync = masked_luma;
            default:           line_sync = HSYNC_IN;
        endcase
        frame_sync = (src == VAC_SRC_SEPARATE) ? VSYNC_IN : 1'b0;
    end
    assign PLL_SYNC = line_sync;
    // Mask only removes pulses; bypass passes them raw
    assign LINE_SYNC_OUTPUT = sout_r[MASK_BYPASS_BIT] ? HSYNC_IN
                                                      : HSYNC_IN && !COPY_PROT_MASK;
    assign DC_COUPLED = cfg_r[CFG_DC_COUPLED_BIT];
    assign PHASE_GAIN = phase_r;
    assign SLICER = '{threshold:     slice_a_r[SLICE_THRESH_LSB +: 4],
                      hysteresis_on: slice_b_r[1],
                      lowpass_on:    slice_b_r[0]};

    // Edge detection
    logic ls_d_r, fs_d_r;
    logic ls_trail, ls_lead, fs_lead, fs_trail;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ls_d_r <= 1'b0;
            fs_d_r <= 1'b0;
        end else begin
            ls_d_r <= line_sync;
            fs_d_r <= frame_sync;
        end
    end
    assign ls_trail = ls_d_r && !line_sync;
    assign ls_lead  = !ls_d_r && line_sync;
    assign fs_lead  = !fs_d_r && frame_sync;
    assign fs_trail = fs_d_r && !frame_sync;

    // Clamp timing on pixel ticks
    vac_clamp_state_t cl_st_r;
    logic [15:0] cl_cnt_r, start_cnt;
    logic        coast_line_r, clamp_pulse;
    // 16-bit start lets the clamp skip the whole active line
    assign start_cnt = {start_a_r, start_b_r};
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            coast_line_r <= 1'b0;
        end else if (ls_trail) begin
            coast_line_r <= PLL_COASTING;
        end else if (PLL_COASTING) begin
            coast_line_r <= 1'b1;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cl_st_r  <= VAC_CL_WAIT;
            cl_cnt_r <= 16'h0000;
        end else if (ls_trail) begin
            cl_st_r  <= VAC_CL_DELAY;
            cl_cnt_r <= 16'h0000;
        end else if (PIX_TICK) begin
            case (cl_st_r)
                VAC_CL_DELAY: begin
                    if (cl_cnt_r == start_cnt) begin
                        cl_st_r  <= (width_r == ZERO8) ? VAC_CL_DONE : VAC_CL_ON;
                        cl_cnt_r <= 16'h0001;
                    end else begin
                        cl_cnt_r <= cl_cnt_r + 16'h0001;
                    end
                end
                VAC_CL_ON: begin
                    if (cl_cnt_r[7:0] == width_r) begin
                        cl_st_r <= VAC_CL_DONE;
                    end else begin
                        cl_cnt_r <= cl_cnt_r + 16'h0001;
                    end
                end
                VAC_CL_WAIT, VAC_CL_DONE: ;
                default: cl_st_r <= VAC_CL_WAIT;
            endcase
        end
    end
    assign clamp_pulse = (cl_st_r == VAC_CL_ON)
                       && !(coast_line_r && !pllc_r[COAST_CLAMP_BIT]);
    assign CLAMP_ON = clamp_pulse && !DC_COUPLED;

    // Gain transfer on clamp end or external clamp, timeout otherwise
    logic        clamp_end, ext_sel, ext_d_r, gain_load;
    logic [23:0] gto_r;
    logic        cl_on_d_r;
    assign ext_sel = cfg_r[CFG_EXT_CLAMP_LSB +: 2] != 2'h0;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cl_on_d_r <= 1'b0;
            ext_d_r   <= 1'b0;
        end else begin
            cl_on_d_r <= cl_st_r == VAC_CL_ON;
            ext_d_r   <= EXT_CLAMP_IN;
        end
    end
    assign clamp_end = ext_sel ? (ext_d_r && !EXT_CLAMP_IN)
                               : (cl_on_d_r && cl_st_r != VAC_CL_ON);
    assign gain_load = clamp_end || (gto_r == 24'(GAIN_TIMEOUT - 1));
    always_ff @(posedge CLK) begin
        if (!RST_B || gain_load) begin
            gto_r <= 24'h000000;
        end else begin
            gto_r <= gto_r + 24'h000001;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            for (int i = 0; i < 3; i++) gain_amp_r[i] <= GAIN_RESET;
        end else if (gain_load) begin
            for (int i = 0; i < 3; i++) gain_amp_r[i] <= gain_reg_r[i];
        end
    end
    assign GAIN_AMP_CODES = {gain_amp_r[0], gain_amp_r[1], gain_amp_r[2]};

    // Black-level servo: average pixels per line, accumulate lines
    logic [3:0]  pix_n, pix_cnt_r;
    logic [3:0]  line_n, line_cnt_r;
    logic [9:0]  servo_dac_r [3];
    logic [15:0] acc_r [3];
    logic        sampling;
    // Four bits so the 8-pixel setting neither wraps nor divides by zero
    assign pix_n   = 4'h1 << servo_r[SERVO_PIX_LSB +: 2];
    assign line_n  = 4'(servo_r[SERVO_LINES_LSB +: 3]) + 4'h1;
    assign sampling = clamp_pulse && PIX_TICK && !servo_r[SERVO_OFF_BIT]
                    && pix_cnt_r != pix_n;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pix_cnt_r  <= 4'h0;
            line_cnt_r <= 4'h0;
            for (int i = 0; i < 3; i++) begin
                acc_r[i]       <= 16'h0000;
                servo_dac_r[i] <= {OFFSET_HI_RESET, 2'h0};
            end
        end else if (ls_trail) begin
            pix_cnt_r <= 4'h0;
            if (pix_cnt_r == pix_n) begin
                if (line_cnt_r + 4'h1 == line_n) begin
                    line_cnt_r <= 4'h0;
                    for (int i = 0; i < 3; i++) begin
                        servo_dac_r[i] <= 10'(acc_r[i] / {12'h000, line_n});
                        acc_r[i]       <= 16'h0000;
                    end
                end else begin
                    line_cnt_r <= line_cnt_r + 4'h1;
                end
            end
        end else if (sampling) begin
            pix_cnt_r <= pix_cnt_r + 4'h1;
            acc_r[0] <= acc_r[0] + 16'(BLACK_RED   / pix_n);
            acc_r[1] <= acc_r[1] + 16'(BLACK_GREEN / pix_n);
            acc_r[2] <= acc_r[2] + 16'(BLACK_BLUE  / pix_n);
        end
    end
    assign OFFSET_CTRL.half_range = servo_r[SERVO_HALF_BIT];
    assign OFFSET_CTRL.servo_on   = !servo_r[SERVO_OFF_BIT];
    // Servo off: upper 8 plus bits 7:6 of the low register
    assign OFFSET_CTRL.red   = servo_r[SERVO_OFF_BIT]
        ? {off_hi_r[0], off_lo_r[0][OFFSET_LOW_LSB +: 2]} : servo_dac_r[0];
    assign OFFSET_CTRL.green = servo_r[SERVO_OFF_BIT]
        ? {off_hi_r[1], off_lo_r[1][OFFSET_LOW_LSB +: 2]} : servo_dac_r[1];
    assign OFFSET_CTRL.blue  = servo_r[SERVO_OFF_BIT]
        ? {off_hi_r[2], off_lo_r[2][OFFSET_LOW_LSB +: 2]} : servo_dac_r[2];

    // Line sync period and width over 16 periods, crystal clocks
    logic [15:0] hp_acc_r, hw_acc_r, hp_res_r, hw_res_r;
    logic [4:0]  hp_n_r, hw_n_r;
    logic        first_lead_r;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            hp_acc_r <= 16'h0000;
            hp_n_r   <= 5'h00;
            hp_res_r <= 16'h0000;
            first_lead_r <= 1'b0;
        end else if (ls_lead) begin
            first_lead_r <= 1'b1;
            if (first_lead_r) begin
                if (hp_n_r + 5'h01 == MEAS_WINDOW) begin
                    hp_res_r <= hp_acc_r + 16'(XTAL_TICK);
                    hp_acc_r <= 16'h0000;
                    hp_n_r   <= 5'h00;
                end else begin
                    hp_n_r <= hp_n_r + 5'h01;
                    hp_acc_r <= hp_acc_r + 16'(XTAL_TICK);
                end
            end
        end else if (XTAL_TICK && first_lead_r) begin
            hp_acc_r <= hp_acc_r + 16'h0001;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            hw_acc_r <= 16'h0000;
            hw_n_r   <= 5'h00;
            hw_res_r <= 16'h0000;
        end else if (ls_trail) begin
            if (hw_n_r + 5'h01 == MEAS_WINDOW) begin
                hw_res_r <= hw_acc_r;
                hw_acc_r <= 16'h0000;
                hw_n_r   <= 5'h00;
            end else begin
                hw_n_r <= hw_n_r + 5'h01;
            end
        end else if (XTAL_TICK && line_sync) begin
            hw_acc_r <= hw_acc_r + 16'h0001;
        end
    end

    // Frame sync period and width in lines or 512-clock units
    logic [8:0]  vdiv_r;
    logic        vunit, vstep;
    logic [11:0] vp_acc_r, vw_acc_r, vp_res_r, vw_res_r;
    assign vunit = meas_cfg_r[MEAS_UNIT_BIT];
    always_ff @(posedge CLK) begin
        if (!RST_B || fs_lead) begin
            vdiv_r <= 9'h000;
        end else if (XTAL_TICK) begin
            vdiv_r <= vdiv_r + 9'h001;
        end
    end
    assign vstep = vunit ? (XTAL_TICK && vdiv_r == VUNIT_LAST) : ls_lead;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            vp_acc_r <= 12'h000;
            vp_res_r <= 12'h000;
        end else if (fs_lead) begin
            vp_res_r <= vp_acc_r;
            // Line edge sharing the frame edge belongs to the new frame
            vp_acc_r <= 12'(vstep);
        end else if (vstep) begin
            vp_acc_r <= vp_acc_r + 12'h001;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            vw_acc_r <= 12'h000;
            vw_res_r <= 12'h000;
        end else if (fs_lead) begin
            vw_acc_r <= 12'(vstep);
        end else if (fs_trail) begin
            vw_res_r <= vw_acc_r;
        end else if (vstep && frame_sync) begin
            vw_acc_r <= vw_acc_r + 12'h001;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        dat_nxt = 32'h00000000;
        rd_hit  = 1'b1;
        case (ADR_I)
            RED_OFFSET_HIGH:     dat_nxt[7:0] = off_hi_r[0];
            RED_OFFSET_LOW:      dat_nxt[7:0] = off_lo_r[0];
            GREEN_OFFSET_HIGH:   dat_nxt[7:0] = off_hi_r[1];
            GREEN_OFFSET_LOW:    dat_nxt[7:0] = off_lo_r[1];
            BLUE_OFFSET_HIGH:    dat_nxt[7:0] = off_hi_r[2];
            BLUE_OFFSET_LOW:     dat_nxt[7:0] = off_lo_r[2];
            GAIN_RED:            dat_nxt[7:0] = gain_reg_r[0];
            GAIN_GREEN:          dat_nxt[7:0] = gain_reg_r[1];
            GAIN_BLUE:           dat_nxt[7:0] = gain_reg_r[2];
            CLAMP_START_PIXEL_A: dat_nxt[7:0] = start_a_r;
            CLAMP_START_PIXEL_B: dat_nxt[7:0] = start_b_r;
            CLAMP_WIDTH_PIXELS:  dat_nxt[7:0] = width_r;
            PLL_LOOP_PHASE_GAIN: dat_nxt[7:0] = phase_r;
            INPUT_CONFIG:        dat_nxt[7:0] = cfg_r;
            BLACK_SERVO_CONFIG:  dat_nxt[7:0] = servo_r;
            SLICER_CONFIG_A:     dat_nxt[7:0] = slice_a_r;
            SLICER_CONFIG_B:     dat_nxt[7:0] = slice_b_r;
            PLL_CONTROL:         dat_nxt[7:0] = pllc_r;
            MEAS_CONFIG:         dat_nxt[7:0] = meas_cfg_r;
            SYNC_OUT_CONFIG:     dat_nxt[7:0] = sout_r;
            HPERIOD_HIGH:        dat_nxt[7:0] = hp_res_r[15:8];
            HPERIOD_LOW:         dat_nxt[7:0] = hp_res_r[7:0];
            HWIDTH_HIGH:         dat_nxt[7:0] = hw_res_r[15:8];
            HWIDTH_LOW:          dat_nxt[7:0] = hw_res_r[7:0];
            VPERIOD_HIGH:        dat_nxt[7:0] = {4'h0, vp_res_r[11:8]};
            VPERIOD_LOW:         dat_nxt[7:0] = vp_res_r[7:0];
            VWIDTH_HIGH:         dat_nxt[7:0] = {4'h0, vw_res_r[11:8]};
            VWIDTH_LOW:          dat_nxt[7:0] = vw_res_r[7:0];
            default:             rd_hit = 1'b0;
        endcase
    end
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            DAT_O <= 32'h00000000;
        end else if (CYC_I && STB_I && !WE_I && !ACK_O) begin
            DAT_O <= rd_hit ? dat_nxt : 32'h00000000;
        end
    end
endmodule : vac_clamp_sync_measure

// ==== hdl/vac_pkg.sv ====
// Package for the video front-end clamp, sync and measurement control.
// Assumes one 10 MHz clock; pixel and crystal ticks arrive as enable pulses.
package vac_pkg;
    // Register byte offsets (one byte register per byte address)
    localparam logic [7:0] RED_OFFSET_HIGH      = 8'h18;
    localparam logic [7:0] RED_OFFSET_LOW       = 8'h19;
    localparam logic [7:0] GREEN_OFFSET_HIGH    = 8'h1A;
    localparam logic [7:0] GREEN_OFFSET_LOW     = 8'h1B;
    localparam logic [7:0] BLUE_OFFSET_HIGH     = 8'h1C;
    localparam logic [7:0] BLUE_OFFSET_LOW      = 8'h1D;
    localparam logic [7:0] CLAMP_START_PIXEL_A  = 8'h24;
    localparam logic [7:0] CLAMP_START_PIXEL_B  = 8'h25;
    localparam logic [7:0] CLAMP_WIDTH_PIXELS   = 8'h26;
    localparam logic [7:0] PLL_LOOP_PHASE_GAIN  = 8'h74;
    localparam logic [7:0] INPUT_CONFIG         = 8'h10;
    localparam logic [7:0] GAIN_RED             = 8'h12;
    localparam logic [7:0] GAIN_GREEN           = 8'h14;
    localparam logic [7:0] GAIN_BLUE            = 8'h16;
    localparam logic [7:0] BLACK_SERVO_CONFIG   = 8'h27;
    localparam logic [7:0] SLICER_CONFIG_A      = 8'h30;
    localparam logic [7:0] SLICER_CONFIG_B      = 8'h31;
    localparam logic [7:0] MEAS_BASE            = 8'h40;
    localparam logic [7:0] HPERIOD_HIGH         = 8'h40;
    localparam logic [7:0] HPERIOD_LOW          = 8'h41;
    localparam logic [7:0] HWIDTH_HIGH          = 8'h42;
    localparam logic [7:0] HWIDTH_LOW           = 8'h43;
    localparam logic [7:0] VPERIOD_HIGH         = 8'h44;
    localparam logic [7:0] VPERIOD_LOW          = 8'h45;
    localparam logic [7:0] VWIDTH_HIGH          = 8'h46;
    localparam logic [7:0] VWIDTH_LOW           = 8'h47;
    localparam logic [7:0] MEAS_CONFIG          = 8'h4F;
    localparam logic [7:0] PLL_CONTROL          = 8'h60;
    localparam logic [7:0] SYNC_OUT_CONFIG      = 8'h7A;

    // Field positions
    localparam int CFG_DC_COUPLED_BIT   = 3;
    localparam int CFG_SYNC_SRC_LSB     = 0;
    localparam int CFG_EXT_CLAMP_LSB    = 6;
    localparam int SERVO_OFF_BIT        = 0;
    localparam int SERVO_HALF_BIT       = 1;
    localparam int SERVO_PIX_LSB        = 2;
    localparam int SERVO_LINES_LSB      = 4;
    localparam int COAST_CLAMP_BIT      = 2;
    localparam int MEAS_UNIT_BIT        = 0;
    localparam int MASK_BYPASS_BIT      = 4;
    localparam int SLICE_THRESH_LSB     = 3;
    localparam int OFFSET_LOW_LSB       = 6;

    // Reset values
    localparam logic [7:0] PHASE_GAIN_RESET = 8'h49;
    localparam logic [7:0] GAIN_RESET       = 8'h55;
    localparam logic [7:0] OFFSET_HI_RESET  = 8'h80;
    localparam logic [7:0] ZERO8            = 8'h00;

    // Measurement
    localparam logic [4:0] MEAS_WINDOW      = 5'h10;
    localparam int         VUNIT_XTAL_CLKS  = 512;
    localparam logic [8:0] VUNIT_LAST       = 9'h1FF;

    // Gain update fallback without clamp: 100 ms at 10 MHz
    localparam int CLK_HZ          = 10_000_000;
    localparam int GAIN_TIMEOUT_MS = 100;
    localparam int GAIN_TIMEOUT_CYC = CLK_HZ / 1000 * GAIN_TIMEOUT_MS;

    typedef enum logic [1:0] {
        VAC_SRC_SEPARATE = 2'h0,
        VAC_SRC_COMP_H   = 2'h1,
        VAC_SRC_COMP_LUMA = 2'h3
    } vac_sync_src_t;

    typedef enum logic [1:0] {
        VAC_CL_WAIT  = 2'h0,
        VAC_CL_DELAY = 2'h1,
        VAC_CL_ON    = 2'h3,
        VAC_CL_DONE  = 2'h2
    } vac_clamp_state_t;

    typedef struct packed {
        logic       half_range;
        logic       servo_on;
        logic [9:0] red;
        logic [9:0] green;
        logic [9:0] blue;
    } vac_offset_t;

    typedef struct packed {
        logic [3:0] threshold;
        logic       hysteresis_on;
        logic       lowpass_on;
    } vac_slicer_t;
endpackage : vac_pkg

// ==== testbench/vac_chk.sv ====
// Port checker: bus answer, clamp gating, sync masking, reset values.
// Bound onto the top module; one clock domain.
`timescale 1ns/100ps
module vac_chk (
    input logic        CLK, RST_B, CYC_I, STB_I, ACK_O, DC_COUPLED, CLAMP_ON,
    input logic        PIX_TICK, HSYNC_IN, LUMA_SYNC_IN, COPY_PROT_MASK, PLL_SYNC,
    input logic        LINE_SYNC_OUTPUT,
    input logic [31:0] DAT_O,
    input logic [7:0]  PHASE_GAIN,
    input logic [23:0] GAIN_AMP_CODES
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not answered");
    a_ack_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_dat_upper: assert property (DAT_O[31:8] == 24'h0)
        else $error("upper read bits set");
    a_dc_clamp: assert property (DC_COUPLED && $past(DC_COUPLED) |-> !CLAMP_ON)
        else $error("clamp in dc mode");
    a_sync_mask: assert property (PLL_SYNC |->
        HSYNC_IN || LUMA_SYNC_IN && !COPY_PROT_MASK) else $error("masked sync reached pll");
    a_out_source: assert property (LINE_SYNC_OUTPUT |-> HSYNC_IN || LUMA_SYNC_IN)
        else $error("sync output without sync");
    // A config write may unmask a running clamp between ticks
    a_clamp_tick: assert property ($rose(CLAMP_ON) && !ACK_O |->
        $past(PIX_TICK) && !HSYNC_IN) else $error("clamp start off tick");
    a_reset_vals: assert property (disable iff (1'b0) !RST_B |=> PHASE_GAIN == 8'h49
        && GAIN_AMP_CODES == 24'h555555 && !ACK_O) else $error("bad reset value");
    c_clamp: cover property ($rose(CLAMP_ON));
    c_mask: cover property (COPY_PROT_MASK && LUMA_SYNC_IN && !PLL_SYNC);
    c_out: cover property (LINE_SYNC_OUTPUT && COPY_PROT_MASK);
endmodule : vac_chk

// ==== testbench/vac_src.sv ====
// Video source model: 160-cycle lines, 8-line frames, tick enables.
// Assumes the bench clock; sync levels high while a pulse is on.
`timescale 1ns/100ps
module vac_src (
    input logic  clk, rst_b,
    output logic pix, xtal, hs, vs
);
    logic [7:0] pos_r;
    logic [2:0] line_r;
    always_ff @(posedge clk) begin
        pos_r <= (!rst_b || pos_r == 8'd159) ? 8'd0 : pos_r + 8'd1;
        line_r <= !rst_b ? 3'd0 : line_r + 3'(pos_r == 8'd159);
    end
    // Pixel tick at half rate so clamp edges can be tied to ticks
    assign pix = pos_r[0];
    assign xtal = 1'b1;
    assign hs = pos_r < 8'd4;
    assign vs = line_r < 3'd2;
endmodule : vac_src

// ==== testbench/test_vac_clamp_sync_measure.sv ====
// Bench: register, clamp, sync and measurement scenarios.
// Assumes the source model for sync and ticks; 10 MHz clock.
`timescale 1ns/100ps
module test_vac_clamp_sync_measure;
    import vac_pkg::*;
    logic CLK = 0, RST_B = 0, CYC_I = 0, STB_I = 0, WE_I = 0, ACK_O, DC_COUPLED, CLAMP_ON;
    logic PIX_TICK, XTAL_TICK, HSYNC_IN, VSYNC_IN, LUMA_SYNC_IN, PLL_SYNC, LINE_SYNC_OUTPUT;
    logic COPY_PROT_MASK = 0, PLL_COASTING = 0, EXT_CLAMP_IN = 0;
    logic [7:0] ADR_I = 0, PHASE_GAIN, src [3] = '{8'h00, 8'h01, 8'h03};
    logic [3:0] SEL_I = 4'hF;
    logic [31:0] DAT_I = 0, DAT_O;
    logic [9:0] BLACK_RED = 0, BLACK_GREEN = 0, BLACK_BLUE = 0;
    logic [23:0] GAIN_AMP_CODES;
    vac_slicer_t SLICER;
    vac_offset_t OFFSET_CTRL;
    int err_count = 0, n_checks = 0, k, c_cl, c_ps, c_ls;
    assign LUMA_SYNC_IN = HSYNC_IN;
    always #50 CLK = ~CLK;
    vac_src u_src (.clk(CLK), .rst_b(RST_B), .pix(PIX_TICK), .xtal(XTAL_TICK), .hs(HSYNC_IN),
        .vs(VSYNC_IN));
    vac_clamp_sync_measure #(.GAIN_TIMEOUT(50)) u_dut (.CLK, .RST_B, .CYC_I, .STB_I, .WE_I,
        .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .PIX_TICK, .XTAL_TICK, .HSYNC_IN, .VSYNC_IN,
        .LUMA_SYNC_IN, .COPY_PROT_MASK, .PLL_COASTING, .EXT_CLAMP_IN, .BLACK_RED, .BLACK_GREEN,
        .BLACK_BLUE, .DC_COUPLED, .CLAMP_ON, .PLL_SYNC, .LINE_SYNC_OUTPUT, .PHASE_GAIN, .SLICER,
        .GAIN_AMP_CODES, .OFFSET_CTRL);
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic check(logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    // Reads compare against d; a missing ack ends the run
    task automatic wb(logic we, logic [7:0] a, logic [7:0] d);
        @(posedge CLK);
        {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'b11, we, a, 24'h0, d};
        k = 0;
        do @(negedge CLK); while (ACK_O !== 1'b1 && ++k < 20);
        if (k == 20) begin
            err_count++;
            end_of_test();
        end
        @(posedge CLK);
        {CYC_I, STB_I} <= 2'b00;
        if (!we) check(DAT_O, {24'h0, d});
    endtask : wb
    // Settle one line, then count over four whole lines
    task automatic sample;
        {c_cl, c_ps, c_ls} = 0;
        repeat (160) @(negedge CLK);
        repeat (640) begin
            @(negedge CLK);
            c_cl += (CLAMP_ON === 1'b1);
            c_ps += (PLL_SYNC === 1'b1);
            c_ls += (LINE_SYNC_OUTPUT === 1'b1);
        end
    endtask : sample
    initial begin
        repeat (3) @(posedge CLK);
        RST_B <= 1'b1;
        wb(0, PLL_LOOP_PHASE_GAIN, 8'h49);
        wb(0, GAIN_GREEN, 8'h55);
        wb(0, RED_OFFSET_HIGH, 8'h80);
        wb(1, 8'hF0, 8'h5A);
        wb(0, 8'hF0, 8'h00);
        wb(1, PLL_LOOP_PHASE_GAIN, 8'h4C);
        check(PHASE_GAIN, 8'h4C);
        wb(1, SLICER_CONFIG_A, 8'h50);
        wb(1, SLICER_CONFIG_B, 8'h02);
        check(SLICER, 6'h2A);
        wb(1, BLACK_SERVO_CONFIG, 8'h03);
        wb(1, RED_OFFSET_HIGH, 8'hAB);
        wb(1, RED_OFFSET_LOW, 8'hC0);
        check(OFFSET_CTRL[31:20], 12'hAAF);
        $display("test registers done");
        wb(1, CLAMP_START_PIXEL_B, 8'h31);
        wb(1, CLAMP_WIDTH_PIXELS, 8'h04);
        sample();
        check(c_cl, 32);
        PLL_COASTING <= 1'b1;
        sample();
        check(c_cl, 0);
        wb(1, PLL_CONTROL, 8'h04);
        sample();
        check(c_cl, 32);
        wb(1, INPUT_CONFIG, 8'h08);
        sample();
        check({DC_COUPLED, 8'(c_cl)}, 9'h100);
        $display("test clamp done");
        foreach (src[i]) begin
            wb(1, INPUT_CONFIG, src[i]);
            sample();
            check(c_ps, 16);
        end
        COPY_PROT_MASK <= 1'b1;
        sample();
        check({c_ps[15:0], c_ls[15:0]}, 0);
        wb(1, SYNC_OUT_CONFIG, 8'h10);
        sample();
        check({c_ps[15:0], c_ls[15:0]}, 16);
        COPY_PROT_MASK <= 1'b0;
        wb(1, INPUT_CONFIG, 8'h00);
        // Masked gap spoils one window; wait for it and one clean window
        repeat (5600) @(posedge CLK);
        wb(0, HPERIOD_HIGH, 8'h0A);
        wb(0, HPERIOD_LOW, 8'h00);
        wb(0, HWIDTH_LOW, 8'h40);
        wb(0, VPERIOD_LOW, 8'h08);
        wb(0, VWIDTH_LOW, 8'h02);
        wb(1, GAIN_RED, 8'h60);
        for (k = 0; k < 400 && GAIN_AMP_CODES !== 24'h605555; k++) @(negedge CLK);
        check(k < 400, 1);
        $display("test sync done");
        end_of_test();
    end
endmodule : test_vac_clamp_sync_measure
bind vac_clamp_sync_measure vac_chk u_chk (.CLK, .RST_B, .CYC_I, .STB_I, .ACK_O, .DC_COUPLED,
    .CLAMP_ON, .PIX_TICK, .HSYNC_IN, .LUMA_SYNC_IN, .COPY_PROT_MASK, .PLL_SYNC,
    .LINE_SYNC_OUTPUT, .DAT_O, .PHASE_GAIN, .GAIN_AMP_CODES);
